/* shared/timing_pkg.sv */
`default_nettype none
package timing_pkg;
	localparam logic [7:0] STACK_RESET   = 8'h07;
	localparam logic [7:0] UNUSED_OPCODE = 8'hA5;
	localparam logic [7:0] NOP_OPCODE    = 8'h00;
	localparam logic [3:0] MAX_CLOCKS    = 4'h8;
	localparam logic [15:0] PC_RESET     = 16'h0000;

	typedef struct packed {
		logic [1:0] bytes;
		logic [3:0] clocks;
		logic       cond;
		logic       push;
		logic       pop;
		logic       rel;
	} op_timing_t;

	typedef enum logic [2:0] {
		ST_FETCH = 3'b001,
		ST_EXEC  = 3'b010,
		ST_DONE  = 3'b100
	} issue_state_t;
endpackage
`default_nettype wire

/* shared/timing_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface timing_if;
	import timing_pkg::*;
	logic [7:0] opcode;
	op_timing_t timing;
	modport table_side (input opcode, output timing);
	modport core_side  (output opcode, input timing);
endinterface
`default_nettype wire

/* logic/opcode_timing_rom.sv */
`timescale 1ns/100ps
`default_nettype none
module opcode_timing_rom
	import timing_pkg::*;
(
	// lookup
	timing_if.table_side lut
);
	// ************************************************
	// per-opcode length and clock count
	// ************************************************
	function automatic op_timing_t mk(input logic [1:0] b,
		input logic [3:0] c);
		op_timing_t t;
		t = '0;
		t.bytes = b;
		t.clocks = c;
		return t;
	endfunction

	logic [7:0] op;
	logic [3:0] lo;
	logic [3:0] hi;
	op_timing_t t;

	always_comb begin
		op = (lut.opcode == UNUSED_OPCODE) ? NOP_OPCODE : lut.opcode;
		lo = op[3:0];
		hi = op[7:4];
		t = mk(2'h1, 4'h1);
		if (lo >= 4'h8) begin
			// bank register forms
			t = mk(2'h1, 4'h1);
			if (hi == 4'h7 || hi == 4'hA || hi == 4'h8)
				t = mk(2'h2, 4'h2);
			if (hi == 4'hB) begin
				t = mk(2'h3, 4'h3);
				t.cond = 1'b1;
			end
			if (hi == 4'hD) begin
				t = mk(2'h2, 4'h2);
				t.cond = 1'b1;
			end
		end else if (lo == 4'h6 || lo == 4'h7) begin
			t = mk(2'h1, 4'h2);
			if (hi == 4'h7 || hi == 4'hA || hi == 4'h8)
				t = mk(2'h2, 4'h2);
			if (hi == 4'hB) begin
				t = mk(2'h3, 4'h4);
				t.cond = 1'b1;
			end
		end else if (lo == 4'h5) begin
			t = mk(2'h2, 4'h2);
			if (hi == 4'h8 || hi == 4'h7) t = mk(2'h3, 4'h3);
			if (hi == 4'hB) begin
				t = mk(2'h3, 4'h4);
				t.cond = 1'b1;
			end
			if (hi == 4'hD) begin
				t = mk(2'h3, 4'h3);
				t.cond = 1'b1;
			end
		end else if (lo == 4'h4) begin
			t = mk(2'h2, 4'h2);
			if (hi <= 4'h3 || hi >= 4'hC) t = mk(2'h1, 4'h1);
			if (hi == 4'h8) t = mk(2'h1, 4'h8);
			if (hi == 4'hA) t = mk(2'h1, 4'h4);
			if (hi == 4'hB) begin
				t = mk(2'h3, 4'h3);
				t.cond = 1'b1;
			end
		end else if (lo == 4'h3) begin
			t = mk(2'h2, 4'h2);
			if (hi >= 4'h4 && hi <= 4'h6) t = mk(2'h3, 4'h3);
			if (hi == 4'h8 || hi == 4'h9) t = mk(2'h1, 4'h3);
			if (hi == 4'h7) t = mk(2'h1, 4'h4);
			if (hi == 4'h0 || hi == 4'h1) t = mk(2'h1, 4'h6);
			if (hi >= 4'hE) t = mk(2'h1, 4'h3);
			if (hi == 4'hA) t = mk(2'h1, 4'h1);
		end else if (lo == 4'h2 || lo == 4'h6) begin
			t = mk(2'h2, 4'h2);
			if (hi >= 4'hE) t = mk(2'h1, 4'h3);
			if (hi == 4'hC || hi == 4'hD) t = mk(2'h2, 4'h2);
			if (hi == 4'h0) t = mk(2'h3, 4'h5);
			if (hi == 4'h1) t = mk(2'h3, 4'h5);
			if (hi == 4'hB || hi == 4'hE || hi == 4'hF)
				if (lo == 4'h3) t = mk(2'h1, 4'h1);
			if (hi == 4'hC || hi == 4'hB || hi == 4'hD)
				if (hi != 4'hC && hi != 4'hD) t = mk(2'h1, 4'h1);
			if (hi >= 4'hC) begin
				if (hi == 4'hC) t.push = 1'b1;
				if (hi == 4'hD) t.pop = 1'b1;
			end
			if (hi >= 4'hE && lo == 4'h2) t = mk(2'h1, 4'h3);
			if (hi == 4'hE && lo == 4'h2) t.push = 1'b0;
		end else if (lo == 4'h1) begin
			t = mk(2'h2, 4'h4);
			if (hi[0]) t = mk(2'h2, 4'h4);
		end else if (lo == 4'h0) begin
			t = mk(2'h3, 4'h3);
			t.cond = 1'b1;
			t.rel = 1'b1;
			if (hi == 4'h0) t = mk(2'h1, 4'h1);
			if (hi >= 4'h4 && hi <= 4'h7) begin
				t = mk(2'h2, 4'h2);
				t.cond = 1'b1;
				t.rel = 1'b1;
			end
			if (hi == 4'h8) begin
				t = mk(2'h2, 4'h4);
				t.rel = 1'b1;
			end
			if (hi == 4'h9) t = mk(2'h3, 4'h3);
			if (hi == 4'hA || hi >= 4'hB && hi != 4'hB && hi < 4'hE)
				t = mk(2'h2, 4'h2);
			if (hi >= 4'hE) t = mk(2'h1, 4'h3);
			if (hi == 4'hC) t = mk(2'h2, 4'h2);
			if (hi == 4'hC) t.push = 1'b1;
			if (hi == 4'hD) t.pop = 1'b1;
			if (hi == 4'hB) t = mk(2'h2, 4'h2);
		end
		if (op == 8'hE4 || op == 8'hF4 || op == 8'h23 || op == 8'h33 ||
			op == 8'h03 || op == 8'h13 || op == 8'hC4) begin
			t = mk(2'h1, 4'h1);
		end
		if (op == 8'h22 || op == 8'h32) t = mk(2'h1, 4'h6);
		if (op == 8'hC0) begin
			t = mk(2'h2, 4'h2);
			t.push = 1'b1;
		end
		if (op == 8'hD0) begin
			t = mk(2'h2, 4'h2);
			t.pop = 1'b1;
		end
		lut.timing = t;
	end
endmodule
`default_nettype wire

/* logic/branch_target.sv */
`timescale 1ns/100ps
`default_nettype none
module branch_target (
	// operands
	input  wire logic [15:0] next_pc,
	input  wire logic [7:0]  offset,
	// result
	output logic      [15:0] target
);
	// sign-extended offset from the following instruction
	always_comb begin
		target = next_pc + {{8{offset[7]}}, offset};
	end
endmodule
`default_nettype wire

/* logic/cpu_instruction_cycle_timing.sv */
`timescale 1ns/100ps
`default_nettype none
module cpu_instruction_cycle_timing
	import timing_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// fetch path
	input  wire logic [7:0]  fetch_opcode,
	input  wire logic        fetch_valid,
	input  wire logic [7:0]  rel_offset,
	// branch outcome
	input  wire logic        cond_taken,
	// issue and status
	output logic             issue_ready,
	output logic             instr_done,
	output logic [15:0]      pc_out,
	output logic [7:0]       stack_top_pointer,
	output logic [3:0]       last_clocks,
	output logic [1:0]       last_bytes
);
	// ************************************************
	// lookup and branch adder
	// ************************************************
	timing_if lut ();
	assign lut.opcode = fetch_opcode;

	opcode_timing_rom u_rom (
		.lut (lut.table_side)
	);

	logic [15:0] next_pc;
	logic [15:0] target;

	branch_target u_tgt (
		.next_pc (next_pc),
		.offset  (rel_offset),
		.target  (target)
	);

	// ************************************************
	// issue state and cycle counter
	// ************************************************
	issue_state_t state_reg;
	issue_state_t state_next;
	logic [3:0]   count_reg;
	logic [3:0]   count_next;
	logic [15:0]  pc_reg;
	logic [15:0]  pc_next;
	logic [15:0]  npc_reg;
	logic [15:0]  npc_next;
	logic [15:0]  tgt_reg;
	logic [15:0]  tgt_next;
	logic         jump_reg;
	logic         jump_next;
	logic [7:0]   sp_reg;
	logic [7:0]   sp_next;
	logic         ready_reg;
	logic         ready_next;
	logic         done_reg;
	logic         done_next;
	logic [3:0]   clk_reg;
	logic [3:0]   clk_next;
	logic [1:0]   byt_reg;
	logic [1:0]   byt_next;
	logic [3:0]   dur;
	op_timing_t   t;

	assign next_pc = pc_reg + {14'h0000, lut.timing.bytes};

	always_comb begin
		t = lut.timing;
		state_next = state_reg;
		count_next = count_reg;
		pc_next = pc_reg;
		npc_next = npc_reg;
		tgt_next = tgt_reg;
		jump_next = jump_reg;
		sp_next = sp_reg;
		done_next = 1'b0;
		clk_next = clk_reg;
		byt_next = byt_reg;
		dur = t.clocks;
		// not-taken branches finish a clock early
		if (t.cond && !cond_taken)
			dur = t.clocks - 4'h1;
		case (state_reg)
			ST_FETCH: begin
				if (fetch_valid) begin
					// whole clocks only, no machine cycles
					count_next = dur - 4'h1;
					npc_next = next_pc;
					tgt_next = target;
					jump_next = t.rel && (cond_taken || !t.cond);
					clk_next = dur;
					byt_next = t.bytes;
					if (t.push)
						sp_next = sp_reg + 8'h01;
					if (t.pop)
						sp_next = sp_reg - 8'h01;
					state_next = (dur == 4'h1) ? ST_DONE : ST_EXEC;
				end
			end
			ST_EXEC: begin
				count_next = count_reg - 4'h1;
				if (count_reg == 4'h1)
					state_next = ST_DONE;
			end
			ST_DONE: begin
				done_next = 1'b1;
				pc_next = jump_reg ? tgt_reg : npc_reg;
				state_next = ST_FETCH;
			end
			default: state_next = ST_FETCH;
		endcase
		ready_next = (state_next == ST_FETCH);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_FETCH;
			count_reg <= 4'h0;
			pc_reg <= PC_RESET;
			npc_reg <= PC_RESET;
			tgt_reg <= PC_RESET;
			jump_reg <= 1'b0;
			sp_reg <= STACK_RESET;
			ready_reg <= 1'b1;
			done_reg <= 1'b0;
			clk_reg <= 4'h0;
			byt_reg <= 2'h0;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
			pc_reg <= pc_next;
			npc_reg <= npc_next;
			tgt_reg <= tgt_next;
			jump_reg <= jump_next;
			sp_reg <= sp_next;
			ready_reg <= ready_next;
			done_reg <= done_next;
			clk_reg <= clk_next;
			byt_reg <= byt_next;
		end
	end

	assign issue_ready = ready_reg;
	assign instr_done = done_reg;
	assign pc_out = pc_reg;
	assign stack_top_pointer = sp_reg;
	assign last_clocks = clk_reg;
	assign last_bytes = byt_reg;
endmodule
`default_nettype wire

/* dv/timing_chk_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module timing_chk
	import timing_pkg::*;
(
	// clock and reset
	input wire logic        core_clk,
	input wire logic        rst,
	// fetch path
	input wire logic [7:0]  fetch_opcode,
	input wire logic        fetch_valid,
	// status
	input wire logic        issue_ready,
	input wire logic        instr_done,
	input wire logic [15:0] pc_out,
	input wire logic [7:0]  stack_top_pointer,
	input wire logic [3:0]  last_clocks
);
	// ********
	// age of the running instruction
	// ********
	wire logic take = issue_ready && fetch_valid;
	logic [3:0] age_reg;
	logic [3:0] age_next;
	always_comb begin
		age_next = age_reg + 4'h1;
		if (take)
			age_next = 4'h0;
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			age_reg <= 4'h0;
		else
			age_reg <= age_next;
	end
	default clocking cb @(posedge core_clk); endclocking
	a_done_pulse: assert property (
		disable iff (rst) instr_done |=> !instr_done)
		else $error("done pulse too long");
	a_issue_hold: assert property (
		disable iff (rst) take |=> !issue_ready)
		else $error("ready stayed high after issue");
	a_ready_done: assert property (
		disable iff (rst) $rose(issue_ready) |-> instr_done)
		else $error("ready rose without done");
	a_done_bound: assert property (
		disable iff (rst) take |-> ##[2:9] instr_done)
		else $error("no done within nine clocks");
	a_count_match: assert property (
		disable iff (rst) instr_done |-> age_reg == last_clocks)
		else $error("duration differs from last_clocks");
	a_pc_on_done: assert property (
		disable iff (rst) !$stable(pc_out) |-> instr_done)
		else $error("pc moved without done");
	a_sp_reset: assert property (
		rst |-> stack_top_pointer == STACK_RESET)
		else $error("stack pointer not at reset value");
	a_sp_issue: assert property (
		disable iff (rst) !$stable(stack_top_pointer) |-> $past(take))
		else $error("stack pointer moved off issue");
	a_nop_alias: assert property (
		disable iff (rst) take && fetch_opcode == UNUSED_OPCODE
		|=> last_clocks == 4'h1) else $error("unused opcode not one clock");
endmodule
bind cpu_instruction_cycle_timing timing_chk chk_u (
	.core_clk(core_clk), .rst(rst), .fetch_opcode(fetch_opcode),
	.fetch_valid(fetch_valid), .issue_ready(issue_ready),
	.instr_done(instr_done), .pc_out(pc_out),
	.stack_top_pointer(stack_top_pointer), .last_clocks(last_clocks));
`default_nettype wire

/* dv/code_store.sv */
`timescale 1ns/100ps
`default_nettype none
module code_store (
	// address
	input  wire logic [5:0] idx,
	// fetched byte
	output logic      [7:0] opcode
);
	// ********
	// program bytes offered to the core
	// ********
	localparam logic [7:0] PROG [0:36] = '{
		8'h28, 8'h38, 8'h98, 8'h58, 8'h48, 8'h68, 8'h26, 8'h06, 8'h16,
		8'h53, 8'h43, 8'h63, 8'h85, 8'h75, 8'hE2, 8'hF2, 8'hE0, 8'hF0,
		8'h93, 8'h83, 8'h90, 8'hF6, 8'h76, 8'h86, 8'hC0, 8'hD0, 8'hC6,
		8'hD6, 8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4, 8'hA5,
		8'h00};
	assign opcode = (idx < 6'h25) ? PROG[idx] : 8'h00;
endmodule
`default_nettype wire

/* dv/cpu_instruction_cycle_timing_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module cpu_instruction_cycle_timing_tb;
	import timing_pkg::*;
	logic        core_clk;
	logic        rst;
	logic [7:0]  fetch_opcode;
	logic        fetch_valid;
	logic [7:0]  rel_offset;
	logic        cond_taken;
	logic        issue_ready;
	logic        instr_done;
	logic [15:0] pc_out;
	logic [7:0]  stack_top_pointer;
	logic [3:0]  last_clocks;
	logic [1:0]  last_bytes;
	logic [5:0]  idx;
	logic [7:0]  prog_op;
	int          n_fail;
	int          n_checks;
	int          pc_m;
	int          sp_m;
	int          c_tk;
	int          c_nt;
	cpu_instruction_cycle_timing dut_u (.core_clk(core_clk), .rst(rst),
		.fetch_opcode(fetch_opcode), .fetch_valid(fetch_valid),
		.rel_offset(rel_offset), .cond_taken(cond_taken),
		.issue_ready(issue_ready), .instr_done(instr_done), .pc_out(pc_out),
		.stack_top_pointer(stack_top_pointer), .last_clocks(last_clocks),
		.last_bytes(last_bytes));
	code_store prog_u (.idx(idx), .opcode(prog_op));
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// ********
	// reference model and checks
	// ********
	task automatic check(input string what, input logic [15:0] e,
		input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	function automatic logic [5:0] expect_of(input logic [7:0] op);
		case (op)
			8'h26, 8'h06, 8'h16, 8'hF6, 8'hC6, 8'hD6: begin
				return {2'h1, 4'h2};
			end
			8'hE2, 8'hF2, 8'hE0, 8'hF0, 8'h93, 8'h83: begin
				return {2'h1, 4'h3};
			end
			8'h53, 8'h43, 8'h63, 8'h85, 8'h75, 8'h90: begin
				return {2'h3, 4'h3};
			end
			8'h76, 8'h86, 8'hC0, 8'hD0: begin
				return {2'h2, 4'h2};
			end
			8'h40: begin
				return {2'h2, 4'h0};
			end
			default: begin
				return {2'h1, 4'h1};
			end
		endcase
	endfunction
	task automatic run(input logic [7:0] op, input logic [7:0] off,
		input logic tk, output int n);
		logic [5:0] e;
		e = expect_of(op);
		@(posedge core_clk);
		fetch_opcode <= op;
		rel_offset <= off;
		cond_taken <= tk;
		fetch_valid <= 1'b1;
		@(posedge core_clk);
		fetch_valid <= 1'b0;
		#1;
		check("ready", 16'h0, {15'h0, issue_ready});
		n = 0;
		while (instr_done !== 1'b1) begin
			@(posedge core_clk);
			#1;
			n++;
			if (n > 12) begin
				n_fail++;
				$display("[ERR] done expected 1 seen 0");
				stop_test();
			end
		end
		check("ready done", 16'h1, {15'h0, issue_ready});
		pc_m = pc_m + int'(e[5:4]);
		if (op == 8'h40 && tk)
			pc_m = pc_m + int'($signed(off));
		sp_m = sp_m + int'(op == 8'hC0) - int'(op == 8'hD0);
		check("pc", 16'(pc_m), pc_out);
		check("sp", {8'h0, 8'(sp_m)}, {8'h0, stack_top_pointer});
		check("bytes", {14'h0, e[5:4]}, {14'h0, last_bytes});
		check("clocks", 16'(n), {12'h0, last_clocks});
		if (op != 8'h40)
			check("duration", {12'h0, e[3:0]}, 16'(n));
	endtask
	initial begin
		int n;
		rst = 1'b1;
		fetch_opcode = 8'h00;
		fetch_valid = 1'b0;
		rel_offset = 8'h00;
		cond_taken = 1'b0;
		idx = 6'h0;
		n_fail = 0;
		n_checks = 0;
		pc_m = 0;
		sp_m = 7;
		void'($urandom(39));
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		check("sp reset", 16'h0007, {8'h0, stack_top_pointer});
		for (int i = 0; i < 37; i++) begin
			idx = 6'(i);
			#1;
			run(prog_op, 8'($urandom), 1'($urandom), n);
		end
		$display("opcode table test done");
		run(8'h40, 8'hF0, 1'b1, c_tk);
		run(8'h40, 8'h05, 1'b0, c_nt);
		check("branch gap", 16'h1, 16'(c_tk - c_nt));
		$display("branch test done");
		@(posedge core_clk);
		rst <= 1'b1;
		@(posedge core_clk);
		#1;
		check("pc reset", 16'h0, pc_out);
		check("sp reset", 16'h0007, {8'h0, stack_top_pointer});
		check("clocks reset", 16'h0, {12'h0, last_clocks});
		check("ready reset", 16'h1, {15'h0, issue_ready});
		@(posedge core_clk);
		rst <= 1'b0;
		pc_m = int'(PC_RESET);
		sp_m = int'(STACK_RESET);
		run(8'hC0, 8'h00, 1'b0, n);
		$display("reset test done");
		stop_test();
	end
endmodule
`default_nettype wire
